// file: pkg/sar_adc_regs.vh
// Register map, field positions and timing counts of the SAR ADC control.
// Assumes a byte-wide register port and fc equal to the block clock.
`ifndef SAR_ADC_REGS_VH
`define SAR_ADC_REGS_VH

// Register offsets
`define OFS_CONV_CTRL    8'h26
`define OFS_CONV_TIMING  8'h27
`define OFS_RESULT_LOW   8'h28
`define OFS_RESULT_HIGH  8'h29

// Reset values
`define RST_CONV_CTRL    8'h10
`define RST_CONV_TIMING  6'h00

// conversion_control fields
`define CC_START_BIT     7
`define CC_MODE_HI       6
`define CC_MODE_LO       5
`define CC_GATE_BIT      4
`define CC_CHAN_HI       3

// conversion_timing_control fields
`define CT_LADDER_BIT    5
`define CT_TIME_HI       3
`define CT_TIME_LO       1

// result_low_and_status fields
`define RL_DONE_BIT      5
`define RL_BUSY_BIT      4

// Operating modes
`define MODE_OFF         2'h0
`define MODE_SINGLE      2'h1
`define MODE_REPEAT      2'h3

// Conversion time in fc periods per time code
`define CONV_FC_000      39
`define CONV_FC_010      78
`define CONV_FC_011      156
`define CONV_FC_100      312
`define CONV_FC_101      624
`define CONV_FC_110      1248

// Block clock periods per fc period
`define CLK_PER_FC       1

// Steps per conversion: 2 sample, 10 bit trials, 1 transfer
`define CONV_STEPS       13
`define SAMPLE_STEPS     2
`define LAST_STEP        4'hc

// Start lockout after a 00H control write, in cycles
`define START_HOLD       3'h4

`endif

// file: rtl/sar_adc_control_logic.v
// Control and status logic of a 10-bit successive-approximation ADC:
// registers, conversion sequencing, result capture and completion pulse.
// Assumes the analog ladder, sample-hold and comparator sit outside and
// that stopMode and the register port run on clk.
//
// Overview of operation
// - Start bit launches a conversion and clears itself after one cycle, taken or refused.
// - Mode 00 disabled, 01 single start, 11 repeat; 10 reserved.
// - Gate bit zero enables analog inputs, one disables them.
// - Channel codes 0000 to 0111 pick inputs zero to seven.
// - Control register resets to 10H: gate bit set, channel code 0000.
// - Stop state resets both control registers and blocks their writes.
// - After writing 00H to control, starts are refused four cycles.
// - Ladder bit zero connects only while converting, one always.
// - Time codes give 39 to 1248 fc periods; 001 and 111 reserved.
// - Timing register bits six and seven carry no defined data.
// - Done flag at low result bit 5 shows a finished conversion.
// - Reading the high result clears done; read low first.
// - Busy flag at bit 4 set on start, cleared at single-mode end, mode 00 abort or stop.
// - Low result bits three to zero carry no information.
// - On finish load results, set done and pulse completion together.
// - Single mode converts the selected channel once then stops.
// - Repeat mode restarts after each finish until mode changes.
// - Writing mode 00 aborts at once without storing a result.
// - A new start clears done but keeps the old result until finish.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns

module sar_adc_control_logic (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       clkEn,
  input  wire       stopMode,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWr,
  input  wire       regRd,
  output wire [7:0] regRdData,
  input  wire       compAbove,
  output wire [9:0] dacCode,
  output wire       sampleHold,
  output wire       ladderConnect,
  output wire [2:0] channelSel,
  output wire       analogInputDisable,
  output wire       conversionCompleteIrq
);

`include "sar_adc_regs.vh"

  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  // Cycles in one step for a time code
  function [6:0] stepCycles;
    input [2:0] code;
    integer     fc;
    integer     cyc;
    begin
      case (code)
        3'h0:    fc = `CONV_FC_000;
        3'h2:    fc = `CONV_FC_010;
        3'h3:    fc = `CONV_FC_011;
        3'h4:    fc = `CONV_FC_100;
        3'h5:    fc = `CONV_FC_101;
        // Reserved codes run slowest: safest for the analog side
        default: fc = `CONV_FC_110;
      endcase
      cyc = (fc * `CLK_PER_FC) / `CONV_STEPS;
      stepCycles = cyc[6:0];
    end
  endfunction

  // Mode that may run a conversion
  function modeRuns;
    input [1:0] mode;
    begin
      modeRuns = (mode == `MODE_SINGLE) ||
                 (mode == `MODE_REPEAT);
    end
  endfunction

  reg [7:0] ctrl_q;
  reg [5:0] timing_q;
  reg [7:0] resHigh_q;
  reg [1:0] resLow_q;
  reg       done_q;
  reg       busy_q;
  reg       state_q;
  reg [3:0] step_q;
  reg [6:0] stepCnt_q;
  reg [6:0] stepLen_q;
  reg [9:0] sar_q;
  reg [2:0] hold_q;
  reg       irq_q;
  reg [7:0] rdData_q;
  reg       comp1_q;
  reg       comp2_q;

  wire [1:0] mode      = ctrl_q[`CC_MODE_HI:`CC_MODE_LO];
  wire       ctrlWr    = regWr && (regAddr == `OFS_CONV_CTRL);
  wire       timingWr  = regWr && (regAddr == `OFS_CONV_TIMING);
  wire       highRd    = regRd && (regAddr == `OFS_RESULT_HIGH);
  wire       stepEnd   = (stepCnt_q == stepLen_q - 7'h01);
  wire       bitStep   = (step_q >= `SAMPLE_STEPS) &&
                         (step_q < `LAST_STEP);
  wire [3:0] bitPos    = 4'hb - step_q;
  // Step whose first cycle judges the trial of the step before it
  wire       judgeStep = (step_q > `SAMPLE_STEPS) &&
                         (step_q <= `LAST_STEP);
  wire [3:0] judgePos  = `LAST_STEP - step_q;
  wire       startOk   = ctrl_q[`CC_START_BIT] && (state_q == ST_IDLE) &&
                         modeRuns(mode) && (hold_q == 3'h0);
  wire       finishing = (state_q == ST_CONV) && stepEnd &&
                         (step_q == `LAST_STEP);
  wire       abortWr   = ctrlWr &&
                         (regWrData[6:5] == `MODE_OFF);

  // Comparator is analog and unclocked, so it passes two flops first
  always @(posedge clk) begin
    if (!reset_n) begin
      comp1_q <= 1'b0;
      comp2_q <= 1'b0;
    end else if (clkEn) begin
      comp1_q <= compAbove;
      comp2_q <= comp1_q;
    end
  end

  // Control registers, writes and the start lockout
  always @(posedge clk) begin
    if (!reset_n) begin
      ctrl_q   <= `RST_CONV_CTRL;
      timing_q <= `RST_CONV_TIMING;
      hold_q   <= 3'h0;
    end else if (clkEn) begin
      if (stopMode) begin
        // Stop state holds both at reset values, writes lost
        ctrl_q   <= `RST_CONV_CTRL;
        timing_q <= `RST_CONV_TIMING;
        hold_q   <= 3'h0;
      end else begin
        if (hold_q != 3'h0) begin
          hold_q <= hold_q - 3'h1;
        end
        // Start bit drops after one look, taken or refused
        if (ctrl_q[`CC_START_BIT]) begin
          ctrl_q[`CC_START_BIT] <= 1'b0;
        end
        if (ctrlWr) begin
          ctrl_q <= regWrData;
          if (regWrData == 8'h00) begin
            hold_q <= `START_HOLD;
          end
        end
        // Bits 7:6 are not kept: they read as zero
        if (timingWr) begin
          timing_q <= regWrData[5:0];
        end
      end
    end
  end

  // Conversion sequencer, flags and result capture
  always @(posedge clk) begin
    if (!reset_n) begin
      state_q   <= ST_IDLE;
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
      resHigh_q <= 8'h00;
      resLow_q  <= 2'h0;
      step_q    <= 4'h0;
      stepCnt_q <= 7'h00;
      stepLen_q <= 7'h01;
      sar_q     <= 10'h000;
      irq_q     <= 1'b0;
    end else if (clkEn) begin
      irq_q <= 1'b0;
      if (stopMode) begin
        // Stop abandons the run and loses earlier results
        state_q   <= ST_IDLE;
        busy_q    <= 1'b0;
        done_q    <= 1'b0;
        resHigh_q <= 8'h00;
        resLow_q  <= 2'h0;
        sar_q     <= 10'h000;
        step_q    <= 4'h0;
        stepCnt_q <= 7'h00;
      end else if (abortWr) begin
        // Mode 00 kills the run, result never stored
        state_q   <= ST_IDLE;
        busy_q    <= 1'b0;
        step_q    <= 4'h0;
        stepCnt_q <= 7'h00;
      end else begin
        if (highRd) begin
          done_q <= 1'b0;
        end

        if (startOk) begin
          // Old result stays until this run completes
          state_q   <= ST_CONV;
          busy_q    <= 1'b1;
          done_q    <= 1'b0;
          step_q    <= 4'h0;
          stepCnt_q <= 7'h00;
          sar_q     <= 10'h000;
          stepLen_q <= stepCycles(
            timing_q[`CT_TIME_HI:`CT_TIME_LO]);
        end

        if (state_q == ST_CONV) begin
          if (stepEnd) begin
            stepCnt_q <= 7'h00;
            step_q    <= step_q + 4'h1;
          end else begin
            stepCnt_q <= stepCnt_q + 7'h01;
          end

          // Trial bit up at step start, kept if input is above
          if (bitStep && (stepCnt_q == 7'h00)) begin
            sar_q[bitPos] <= 1'b1;
          end
          // Judge a trial one step late: the sync flops need three
          // edges and the shortest step is only three cycles long
          if (judgeStep && (stepCnt_q == 7'h00) && !comp2_q) begin
            sar_q[judgePos] <= 1'b0;
          end

          if (finishing) begin
            resHigh_q <= sar_q[9:2];
            resLow_q  <= sar_q[1:0];
            done_q    <= 1'b1;
            irq_q     <= 1'b1;
            if (mode == `MODE_REPEAT) begin
              // Next run follows with no idle cycle
              step_q    <= 4'h0;
              stepCnt_q <= 7'h00;
              sar_q     <= 10'h000;
              stepLen_q <= stepCycles(
                timing_q[`CT_TIME_HI:`CT_TIME_LO]);
            end else begin
              state_q <= ST_IDLE;
              busy_q  <= 1'b0;
            end
          end
        end
      end
    end
  end

  // Read data registered, valid the cycle after the strobe
  always @(posedge clk) begin
    if (!reset_n) begin
      rdData_q <= 8'h00;
    end else if (clkEn) begin
      rdData_q <= 8'h00;
      if (regRd) begin
        case (regAddr)
          `OFS_CONV_CTRL: begin
            rdData_q <= ctrl_q;
          end
          `OFS_CONV_TIMING: begin
            // Top two bits read zero
            rdData_q <= {2'h0, timing_q};
          end
          `OFS_RESULT_LOW: begin
            // Low nibble has nothing to show, reads zero
            rdData_q <= {resLow_q, done_q, busy_q,
                         4'h0};
          end
          `OFS_RESULT_HIGH: begin
            rdData_q <= resHigh_q;
          end
          default: begin
            rdData_q <= 8'h00;
          end
        endcase
      end
    end
  end

  // Analog-side controls straight from state flops
  assign regRdData             = rdData_q;
  assign dacCode               = sar_q;
  assign sampleHold            = busy_q &&
                                 (step_q < `SAMPLE_STEPS);
  assign ladderConnect         = busy_q ||
                                 timing_q[`CT_LADDER_BIT];
  assign channelSel            = ctrl_q[2:0];
  assign analogInputDisable    = ctrl_q[`CC_GATE_BIT];
  assign conversionCompleteIrq = irq_q;

endmodule

// file: test/comparator_model.sv
// Comparator model standing on the analog side of the ADC control.
// Assumes dacCode and channelSel come straight from the block.
`timescale 1ns/1ns
module comparator_model (
  input  wire [9:0] dacCode,
  input  wire [2:0] channelSel,
  output wire       compAbove
);
  // Fixed level per channel, distinct in the high result bits; low result bits are 01 for every channel
  wire [9:0] level = {channelSel, ~channelSel, 4'h5};
  // Input at or above the trial keeps the bit
  assign compAbove = level >= dacCode;
endmodule

// file: test/sar_adc_control_logic_chk.sv
// Port assertions for the SAR ADC control block.
// Assumes clkEn stays high, so every edge counts.
`timescale 1ns/1ns
`include "sar_adc_regs.vh"
module sar_adc_chk (
  input wire       clk,
  input wire       reset_n,
  input wire       stopMode,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire       regWr,
  input wire       regRd,
  input wire [7:0] regRdData,
  input wire       sampleHold,
  input wire       ladderConnect,
  input wire [2:0] channelSel,
  input wire       analogInputDisable,
  input wire       conversionCompleteIrq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Decoded strobes; stop blocks control writes
  wire wrCtrl = regWr && regAddr == `OFS_CONV_CTRL && !stopMode;
  wire rdLow  = regRd && regAddr == `OFS_RESULT_LOW;
  wire rdHigh = regRd && regAddr == `OFS_RESULT_HIGH;
  irqPulse_a: assert property (
    conversionCompleteIrq |=> !conversionCompleteIrq)
    else $error("completion pulse too long");
  chanGate_a: assert property (
    wrCtrl |=> ##1 (analogInputDisable == $past(regWrData[4], 2)
      && channelSel == $past(regWrData[2:0], 2)))
    else $error("gate or channel not taken");
  ladderOn_a: assert property (
    regWr && regAddr == `OFS_CONV_TIMING && regWrData[5] && !stopMode
      |=> ##1 ladderConnect)
    else $error("ladder not held on");
  stopInit_a: assert property (
    stopMode [*2] |=> analogInputDisable && channelSel == 3'h0
      && !ladderConnect && !sampleHold)
    else $error("stop left state behind");
  abortQuiet_a: assert property (
    wrCtrl && regWrData[6:5] == `MODE_OFF
      |=> ##1 (!conversionCompleteIrq && !sampleHold) [*8])
    else $error("activity after disable");
  lowBits_a: assert property (
    rdLow |=> regRdData[3:0] == 4'h0)
    else $error("low result bits not zero");
  startClr_a: assert property (
    wrCtrl ##2 (regRd && regAddr == `OFS_CONV_CTRL) |=> !regRdData[7])
    else $error("start bit not cleared");
  doneClr_a: assert property (
    rdHigh ##1 !conversionCompleteIrq ##1 (rdLow && !conversionCompleteIrq)
      |=> !regRdData[`RL_DONE_BIT])
    else $error("done not cleared by high read");
  cover property (conversionCompleteIrq);
  cover property (stopMode ##1 !stopMode);
  cover property (wrCtrl && regWrData[6:5] == `MODE_REPEAT);
endmodule
bind sar_adc_control_logic sar_adc_chk chk (.clk, .reset_n, .stopMode,
  .regAddr, .regWrData, .regWr, .regRd, .regRdData, .sampleHold,
  .ladderConnect, .channelSel, .analogInputDisable, .conversionCompleteIrq);

// file: test/tb.sv
// Self-checking bench for the SAR ADC control block.
// Assumes the comparator model on the analog side; clkEn tied high.
`timescale 1ns/1ns
`include "sar_adc_regs.vh"
module tb;
  logic       clk, reset_n, stopMode, regWr, regRd;
  logic [7:0] regAddr, regWrData, v;
  logic [9:0] res;
  wire  [7:0] regRdData;
  wire  [9:0] dacCode;
  wire  [2:0] channelSel;
  wire        compAbove, sampleHold, ladderConnect, gateOff, irq;
  int         miscompares, samples_checked, n;
  typedef struct { logic [2:0] ch, code; int fc; } row_t;
  // Every channel once; every time code, reserved ones too
  row_t rows [8] = '{'{3'h0, 3'h0, 39}, '{3'h1, 3'h1, 1248},
    '{3'h2, 3'h2, 78}, '{3'h3, 3'h3, 156}, '{3'h4, 3'h4, 312},
    '{3'h5, 3'h5, 624}, '{3'h6, 3'h6, 1248}, '{3'h7, 3'h7, 1248}};
  sar_adc_control_logic DUT (.clk, .reset_n, .clkEn(1'b1), .stopMode,
    .regAddr, .regWrData, .regWr, .regRd, .regRdData, .compAbove,
    .dacCode, .sampleHold, .ladderConnect, .channelSel,
    .analogInputDisable(gateOff), .conversionCompleteIrq(irq));
  comparator_model CMP (.dacCode, .channelSel, .compAbove);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One-cycle strobes; data sampled after the answering edge
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdData;
  endtask
  task automatic waitIrq(input int lim);
    for (n = 0; n < lim; n++) begin
      @(posedge clk);
      #1 if (irq === 1'b1) break;
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    {reset_n, stopMode, regWr, regRd, regAddr, regWrData} = '0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(`OFS_CONV_CTRL);
    chk(v, 8'h10);
    rd(8'h40);
    chk(v, 8'h00);
    $display("reset test done");
    foreach (rows[i]) begin
      res = {rows[i].ch, ~rows[i].ch, 4'h5};
      wr(`OFS_CONV_TIMING, {4'h1, rows[i].code, 1'b0});
      wr(`OFS_CONV_CTRL, {5'h04, rows[i].ch});
      wr(`OFS_CONV_CTRL, {5'h14, rows[i].ch});
      rd(`OFS_CONV_CTRL);
      chk(v, {5'h04, rows[i].ch});
      chk({gateOff, channelSel}, {1'b0, rows[i].ch});
      rd(`OFS_RESULT_LOW);
      chk(v[5:4], 2'b01);
      chk(ladderConnect, 1'b1);
      waitIrq(1400);
      chk(n + 6 >= rows[i].fc && n <= rows[i].fc, 1'b1);
      rd(`OFS_RESULT_LOW);
      chk(v[7:4], {res[1:0], 2'b10});
      rd(`OFS_RESULT_HIGH);
      chk(v, res[9:2]);
      rd(`OFS_RESULT_LOW);
      chk({v[5], ladderConnect}, 2'b00);
      $display("row %0d done", i);
    end
    // Restart before reading: old result must survive until finish
    wr(`OFS_CONV_TIMING, 8'h10);
    wr(`OFS_CONV_CTRL, 8'ha2);
    waitIrq(60);
    wr(`OFS_CONV_CTRL, 8'h25);
    wr(`OFS_CONV_CTRL, 8'ha5);
    rd(`OFS_RESULT_LOW);
    chk(v[7:5], 3'b010);
    rd(`OFS_RESULT_HIGH);
    chk(v, 8'h55);
    waitIrq(60);
    rd(`OFS_RESULT_HIGH);
    chk(v, 8'ha9);
    $display("restart test done");
    // Start right after a 00H write, then a start while disabled
    wr(`OFS_CONV_CTRL, 8'h00);
    wr(`OFS_CONV_CTRL, 8'ha1);
    rd(`OFS_RESULT_LOW);
    chk(v[4], 1'b0);
    wr(`OFS_CONV_CTRL, 8'h81);
    waitIrq(60);
    chk(n, 60);
    $display("refusal test done");
    // Repeat runs on by itself until a mode 00 write cuts it short
    wr(`OFS_CONV_CTRL, 8'he4);
    waitIrq(60);
    waitIrq(60);
    chk(n < 60, 1'b1);
    repeat (10) @(posedge clk);
    wr(`OFS_CONV_CTRL, 8'h04);
    waitIrq(60);
    chk(n, 60);
    $display("repeat test done");
    // Stop mid-conversion with the ladder forced on
    wr(`OFS_CONV_TIMING, 8'h30);
    wr(`OFS_CONV_CTRL, 8'ha3);
    @(posedge clk) stopMode <= 1'b1;
    wr(`OFS_CONV_CTRL, 8'h23);
    rd(`OFS_CONV_CTRL);
    chk(v, 8'h10);
    rd(`OFS_CONV_TIMING);
    chk(v, 8'h00);
    rd(`OFS_RESULT_LOW);
    chk({v[5:4], ladderConnect}, 3'b000);
    @(posedge clk) stopMode <= 1'b0;
    $display("stop test done");
    summarize;
  end
  // Rows need about 5000 cycles; the rest a few hundred
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize;
  end
endmodule
